// >>> mbli_params.svh
`ifndef MBLI_PARAMS_SVH
`define MBLI_PARAMS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define MBLI_ADDR_W      24
`define MBLI_LO_W        16
`define MBLI_EXT_W       8

// ****************************************************************
// field positions
// ****************************************************************
`define MBLI_UPPER_MSB   15
`define MBLI_UPPER_LSB   8
`define MBLI_LOWER_MSB   7
`define MBLI_LOWER_LSB   0
`define MBLI_BURST_MSB   3
`define MBLI_BURST_LSB   1
`define MBLI_BURST_EXT_MSB 3

// ****************************************************************
// reset values
// ****************************************************************
`define MBLI_ADDR_RST    24'h000000
`define MBLI_LO_RST      16'h0000
`define MBLI_EXT_RST     8'h00
`define MBLI_DATA_RST    16'h0000
`define MBLI_BYTE_RST    8'h00
`define MBLI_EN_RST      2'h0

`endif

// >>> mbli_pkg.sv
package mbli_pkg;

    // ****************************************************************
    // host bus flavours
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_MUX_BHE,
        MODE_MUX_WRLH,
        MODE_MUX_BURST,
        MODE_NM_WRLH,
        MODE_NM_SIZE,
        MODE_NM_DSTRB
    } mbli_mode_t;

    typedef struct packed {
        mbli_mode_t mode;
        logic       strobe_high;
        logic       strobe_used;
    } mbli_cfg_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic even;
        logic odd;
    } mbli_strb_t;

    typedef struct packed {
        logic [7:0] odd;
        logic [7:0] even;
    } mbli_word_t;

endpackage

// >>> mbli_addr_latch.sv
`timescale 1ns/10ps
`include "mbli_params.svh"

module mbli_addr_latch #(
    parameter int          W   = 16,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         load_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    always_comb begin
        nxt_q = load_i ? d_i : q_ff;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_ff <= RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;

endmodule

// >>> mbli_lane_dec.sv
`timescale 1ns/10ps
`include "mbli_params.svh"

module mbli_lane_dec (
    input  wire mbli_pkg::mbli_mode_t mode_i,
    input  wire logic                 control_pin_zero,
    input  wire logic                 control_pin_one,
    input  wire logic                 control_pin_two,
    input  wire logic                 port_d_bit_three,
    input  wire logic                 a0_i,
    output mbli_pkg::mbli_strb_t      strb_o
);

    // ****************************************************************
    // strobe roles per bus flavour
    // ****************************************************************
    always_comb begin
        strb_o = '0;
        unique case (mode_i)
            mbli_pkg::MODE_MUX_BHE: begin
                strb_o.wr   = !control_pin_zero;
                strb_o.rd   = !control_pin_one;
                strb_o.even = !a0_i;
                strb_o.odd  = !control_pin_two;
            end
            mbli_pkg::MODE_MUX_WRLH, mbli_pkg::MODE_MUX_BURST, mbli_pkg::MODE_NM_WRLH: begin
                // program store enable reads like the read strobe
                strb_o.rd   = !control_pin_one
                            | ((mode_i == mbli_pkg::MODE_MUX_BURST) && !control_pin_two);
                strb_o.wr   = !control_pin_zero | !port_d_bit_three;
                // no byte qualifier on reads here, so both lanes answer
                strb_o.even = strb_o.rd | !control_pin_zero;
                strb_o.odd  = strb_o.rd | !port_d_bit_three;
            end
            mbli_pkg::MODE_NM_SIZE: begin
                strb_o.rd   = !control_pin_one && control_pin_zero;
                strb_o.wr   = !control_pin_one && !control_pin_zero;
                strb_o.even = !a0_i;
                strb_o.odd  = !control_pin_two || a0_i;
            end
            mbli_pkg::MODE_NM_DSTRB: begin
                strb_o.rd   = (!control_pin_one || !control_pin_two) && control_pin_zero;
                strb_o.wr   = (!control_pin_one || !control_pin_two) && !control_pin_zero;
                strb_o.even = !control_pin_one;
                strb_o.odd  = !control_pin_two;
            end
            default: strb_o = '0;
        endcase
    end

endmodule

// >>> mbli_top.sv
`timescale 1ns/10ps
`include "mbli_params.svh"

// Notes on behaviour
// - non-multiplexed: address on shared port, data on ports f/g, floated when idle
// - non-multiplexed: address bits above sixteen come in through ports a-c
// - multiplexed with byte-high: write on pin zero, read on pin one
// - unused pin two feeds logic; unused port d/f pins flagged free
// - non-multiplexed bus works with the address strobe left off
// - address bit zero low is the even byte, high the odd byte
// - byte-high mode: odd byte upper lane, even byte lower lane
// - dual write strobes: high strobe odd upper, low strobe even lower
// - size-bit mode: even byte upper lane, odd byte lower lane
// - data-strobe mode: upper strobe even upper, lower strobe odd lower
// - multiplexed without byte-high: low write on pin zero, high on port d three
// - address above multiplexed range enters through ports a-c
// - size-bit host: read/write, data strobe, size on pins zero to two
// - data bits 0-7 on port f, bits 8-15 on port g
// - burst: upper address held, low bits stepped from port f
// - burst host: read pin one, store enable pin two, writes pin zero/port d
// - byte-enable host: read/write pin zero, byte enables on pins one and two
// - multiplexed: strobe latches address; bus driven only on selected read
module mbli_top (
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire mbli_pkg::mbli_cfg_t   cfg_i,
    input  wire logic [15:0]           shared_addr_data_port_i,
    output logic      [15:0]           shared_addr_data_port_o,
    output logic                       shared_addr_data_port_oe,
    input  wire logic                  control_pin_zero,
    input  wire logic                  control_pin_one,
    input  wire logic                  control_pin_two,
    input  wire logic                  port_d_bit_three,
    input  wire logic                  port_d_bit_zero,
    input  wire logic [7:0]            port_f_i,
    output logic      [7:0]            port_f_o,
    output logic                       port_f_oe,
    input  wire logic [7:0]            port_g_i,
    output logic      [7:0]            port_g_o,
    output logic                       port_g_oe,
    input  wire logic [7:0]            port_abc_addr_i,
    input  wire logic                  select_i,
    input  wire mbli_pkg::mbli_word_t  rd_data_i,
    output logic      [23:0]           addr_o,
    output logic      [1:0]            rd_en_o,
    output logic      [1:0]            wr_en_o,
    output mbli_pkg::mbli_word_t       wr_data_o,
    output logic                       pld_control_pin_two_o,
    output logic                       control_pin_two_free_o,
    output logic                       port_d3_free_o,
    output logic                       port_f_nib_free_o
);

    // ****************************************************************
    // flavour decode
    // ****************************************************************
    logic                 is_mux;
    logic                 is_burst;
    logic                 even_upper;
    logic                 latch_en;
    logic                 lo_load;
    logic [15:0]          lo_q;
    logic [15:0]          lo_now;
    logic [7:0]           ext_q;
    logic [7:0]           ext_now;
    mbli_pkg::mbli_strb_t strb;

    always_comb begin
        is_mux     = (cfg_i.mode == mbli_pkg::MODE_MUX_BHE)
                   || (cfg_i.mode == mbli_pkg::MODE_MUX_WRLH)
                   || (cfg_i.mode == mbli_pkg::MODE_MUX_BURST);
        is_burst   = (cfg_i.mode == mbli_pkg::MODE_MUX_BURST);
        even_upper = (cfg_i.mode == mbli_pkg::MODE_NM_SIZE)
                   || (cfg_i.mode == mbli_pkg::MODE_NM_DSTRB);
        latch_en   = cfg_i.strobe_high ? port_d_bit_zero : !port_d_bit_zero;
        // without a strobe the non-multiplexed address is taken live
        lo_load    = latch_en && (is_mux || cfg_i.strobe_used);
        lo_now     = lo_load ? shared_addr_data_port_i : lo_q;
        ext_now    = lo_load ? port_abc_addr_i : ext_q;
        if (!is_mux && !cfg_i.strobe_used) begin
            lo_now  = shared_addr_data_port_i;
            ext_now = port_abc_addr_i;
        end
    end

    // ****************************************************************
    // address latches
    // ****************************************************************
    mbli_addr_latch #(
        .W   (`MBLI_LO_W),
        .RST (`MBLI_LO_RST)
    ) u_lo_latch (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .load_i  (lo_load),
        .d_i     (shared_addr_data_port_i),
        .q_o     (lo_q)
    );

    mbli_addr_latch #(
        .W   (`MBLI_EXT_W),
        .RST (`MBLI_EXT_RST)
    ) u_ext_latch (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .load_i  (lo_load),
        .d_i     (port_abc_addr_i),
        .q_o     (ext_q)
    );

    mbli_lane_dec u_lane_dec (
        .mode_i           (cfg_i.mode),
        .control_pin_zero (control_pin_zero),
        .control_pin_one  (control_pin_one),
        .control_pin_two  (control_pin_two),
        .port_d_bit_three (port_d_bit_three),
        .a0_i             (lo_now[0]),
        .strb_o           (strb)
    );

    // ****************************************************************
    // registered bus side
    // ****************************************************************
    logic [23:0]          addr_ff;
    logic [23:0]          nxt_addr;
    logic [1:0]           rd_en_ff;
    logic [1:0]           nxt_rd_en;
    logic [1:0]           wr_en_ff;
    logic [1:0]           nxt_wr_en;
    mbli_pkg::mbli_word_t wr_data_ff;
    mbli_pkg::mbli_word_t nxt_wr_data;
    logic [15:0]          shared_addr_data_port_o_ff;
    logic [15:0]          nxt_shared_addr_data_port_o;
    logic                 shared_addr_data_port_oe_ff;
    logic                 nxt_shared_addr_data_port_oe;
    logic [7:0]           pf_o_ff;
    logic [7:0]           pg_o_ff;
    logic [7:0]           nxt_pf_o;
    logic [7:0]           nxt_pg_o;
    logic                 pf_oe_ff;
    logic                 pg_oe_ff;
    logic                 nxt_pf_oe;
    logic                 nxt_pg_oe;
    logic                 control_pin_two_free_ff;
    logic                 nxt_control_pin_two_free;
    logic                 pld_control_pin_two_ff;
    logic                 nxt_pld_control_pin_two;
    logic                 pd3_free_ff;
    logic                 nxt_pd3_free;
    logic                 pf_nib_free_ff;
    logic                 nxt_pf_nib_free;
    logic                 drive;
    logic                 upper_en;
    logic                 lower_en;
    logic [15:0]          bus_in;
    logic [15:0]          rd_lanes;

    always_comb begin
        if (is_burst) begin
            nxt_addr = {ext_now[`MBLI_BURST_EXT_MSB:0], lo_now,
                        port_f_i[`MBLI_BURST_MSB:`MBLI_BURST_LSB], 1'b0};
        end else begin
            nxt_addr = {ext_now, lo_now};
        end
        // write data sampled from the port the flavour uses
        bus_in   = is_mux ? shared_addr_data_port_i : {port_g_i, port_f_i};
        rd_lanes = even_upper ? {rd_data_i.even, rd_data_i.odd}
                              : {rd_data_i.odd, rd_data_i.even};
        upper_en = even_upper ? strb.even : strb.odd;
        lower_en = even_upper ? strb.odd : strb.even;
        drive    = select_i && strb.rd;
        nxt_rd_en = {drive && strb.odd, drive && strb.even};
        nxt_wr_en = {select_i && strb.wr && strb.odd,
                     select_i && strb.wr && strb.even};
        nxt_wr_data = wr_data_ff;
        if (select_i && strb.wr) begin
            if (even_upper) begin
                nxt_wr_data = {bus_in[`MBLI_LOWER_MSB:`MBLI_LOWER_LSB],
                               bus_in[`MBLI_UPPER_MSB:`MBLI_UPPER_LSB]};
            end else begin
                nxt_wr_data = bus_in;
            end
        end
        nxt_shared_addr_data_port_o  = rd_lanes;
        nxt_shared_addr_data_port_oe = is_mux && drive;
        nxt_pg_o    = rd_lanes[`MBLI_UPPER_MSB:`MBLI_UPPER_LSB];
        nxt_pf_o    = rd_lanes[`MBLI_LOWER_MSB:`MBLI_LOWER_LSB];
        // idle data ports float so the host owns the bus
        nxt_pg_oe   = !is_mux && drive && upper_en;
        nxt_pf_oe   = !is_mux && drive && lower_en;
        nxt_control_pin_two_free  = (cfg_i.mode == mbli_pkg::MODE_MUX_WRLH)
                       || (cfg_i.mode == mbli_pkg::MODE_NM_WRLH);
        nxt_pld_control_pin_two   = nxt_control_pin_two_free && control_pin_two;
        nxt_pd3_free    = !((cfg_i.mode == mbli_pkg::MODE_MUX_WRLH)
                       || (cfg_i.mode == mbli_pkg::MODE_NM_WRLH) || is_burst);
        // port f carries data when non-multiplexed, address in burst
        nxt_pf_nib_free = is_mux && !is_burst;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff        <= `MBLI_ADDR_RST;
            rd_en_ff       <= `MBLI_EN_RST;
            wr_en_ff       <= `MBLI_EN_RST;
            wr_data_ff     <= `MBLI_DATA_RST;
            shared_addr_data_port_o_ff      <= `MBLI_DATA_RST;
            shared_addr_data_port_oe_ff     <= 1'b0;
            pf_o_ff        <= `MBLI_BYTE_RST;
            pg_o_ff        <= `MBLI_BYTE_RST;
            pf_oe_ff       <= 1'b0;
            pg_oe_ff       <= 1'b0;
            control_pin_two_free_ff  <= 1'b0;
            pld_control_pin_two_ff   <= 1'b0;
            pd3_free_ff    <= 1'b0;
            pf_nib_free_ff <= 1'b0;
        end else begin
            addr_ff        <= nxt_addr;
            rd_en_ff       <= nxt_rd_en;
            wr_en_ff       <= nxt_wr_en;
            wr_data_ff     <= nxt_wr_data;
            shared_addr_data_port_o_ff      <= nxt_shared_addr_data_port_o;
            shared_addr_data_port_oe_ff     <= nxt_shared_addr_data_port_oe;
            pf_o_ff        <= nxt_pf_o;
            pg_o_ff        <= nxt_pg_o;
            pf_oe_ff       <= nxt_pf_oe;
            pg_oe_ff       <= nxt_pg_oe;
            control_pin_two_free_ff  <= nxt_control_pin_two_free;
            pld_control_pin_two_ff   <= nxt_pld_control_pin_two;
            pd3_free_ff    <= nxt_pd3_free;
            pf_nib_free_ff <= nxt_pf_nib_free;
        end
    end

    assign addr_o                   = addr_ff;
    assign rd_en_o                  = rd_en_ff;
    assign wr_en_o                  = wr_en_ff;
    assign wr_data_o                = wr_data_ff;
    assign shared_addr_data_port_o  = shared_addr_data_port_o_ff;
    assign shared_addr_data_port_oe = shared_addr_data_port_oe_ff;
    assign port_f_o                 = pf_o_ff;
    assign port_g_o                 = pg_o_ff;
    assign port_f_oe                = pf_oe_ff;
    assign port_g_oe                = pg_oe_ff;
    assign control_pin_two_free_o             = control_pin_two_free_ff;
    assign pld_control_pin_two_o              = pld_control_pin_two_ff;
    assign port_d3_free_o           = pd3_free_ff;
    assign port_f_nib_free_o        = pf_nib_free_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_mux_bus_drive: assert property (
        shared_addr_data_port_oe_ff |-> $past(is_mux) && $past(select_i) && $past(strb.rd))
        else $error("shared port driven outside a selected read");

    a_nm_idle_float: assert property (
        (!is_mux && !(select_i && strb.rd)) |=> !port_f_oe && !port_g_oe)
        else $error("data ports driven while host idle");

    a_bhe_word_wr: assert property (
        (cfg_i.mode == mbli_pkg::MODE_MUX_BHE && select_i && !control_pin_zero
         && !control_pin_two && !lo_now[0]) |=> wr_en_o == 2'h3)
        else $error("byte-high word write lost a lane");

    a_wrl_only: assert property (
        (cfg_i.mode == mbli_pkg::MODE_NM_WRLH && select_i && !control_pin_zero
         && port_d_bit_three && control_pin_one) |=> wr_en_o == 2'h1)
        else $error("low write strobe enabled wrong byte");

    a_size_byte_sel: assert property (
        (cfg_i.mode == mbli_pkg::MODE_NM_SIZE && select_i && !control_pin_one
         && !control_pin_zero && control_pin_two && lo_now[0]) |=> wr_en_o == 2'h2)
        else $error("size mode odd byte select wrong");

    a_dstrb_swap: assert property (
        (cfg_i.mode == mbli_pkg::MODE_NM_DSTRB && select_i && !control_pin_zero
         && !control_pin_one) |=> wr_data_o.even == $past(port_g_i))
        else $error("upper strobe did not take even byte from upper lane");

    a_burst_hold: assert property (
        (is_burst && !latch_en) [*2] |-> $stable(addr_o[19:4])
         && addr_o[3:1] == $past(port_f_i[3:1]))
        else $error("burst upper address moved or low bits not followed");

    a_nm_live_addr: assert property (
        (!is_mux && !cfg_i.strobe_used) |=> addr_o[15:0] == $past(shared_addr_data_port_i))
        else $error("strobe-less address not taken live");

    a_control_pin_two_to_pld: assert property (
        control_pin_two_free_o |-> pld_control_pin_two_o == $past(control_pin_two))
        else $error("free pin two not passed to logic");

endmodule

// >>> mbli_host.sv
`timescale 1ns/10ps

// ****
// host side of the bus
// ****
module mbli_host (
    input  wire logic        sys_clk,
    input  wire logic [15:0] shared_o,
    input  wire logic        shared_oe,
    input  wire logic [7:0]  f_o,
    input  wire logic        f_oe,
    input  wire logic [7:0]  g_o,
    input  wire logic        g_oe,
    output logic      [15:0] shared_i,
    output logic      [7:0]  f_i,
    output logic      [7:0]  g_i,
    output logic             c0,
    output logic             c1,
    output logic             c2,
    output logic             pd3,
    output logic             pd0
);
    logic [15:0] bus_v;
    logic [15:0] dat_v;
    logic        bus_own;
    logic        d_own;

    // released lines show the inverse, so stale values never pass
    assign shared_i = shared_oe ? shared_o : (bus_own ? bus_v : ~bus_v);
    assign f_i = f_oe ? f_o : (d_own ? dat_v[7:0] : ~dat_v[7:0]);
    assign g_i = g_oe ? g_o : (d_own ? dat_v[15:8] : ~dat_v[15:8]);

    initial begin
        bus_v = 16'h0000;
        dat_v = 16'h0000;
        bus_own = 1'b1;
        d_own = 1'b1;
        {c0, c1, c2, pd3} = 4'hf;
        pd0 = 1'b0;
    end

    task automatic strobe(input logic [15:0] adr);
        begin
            bus_v = adr;
            bus_own = 1'b1;
            dat_v = 16'h0000;
            d_own = 1'b1;
            pd0 = 1'b1;
            @(negedge sys_clk);
        end
    endtask

    task automatic access(input logic [3:0] pins, input logic [15:0] data,
                          input logic wr, input logic mux);
        begin
            pd0 = 1'b0;
            {c0, c1, c2, pd3} = pins;
            if (mux) begin
                bus_own = wr;
                if (wr) bus_v = data;
            end else begin
                d_own = wr;
                if (wr) dat_v = data;
            end
            @(negedge sys_clk);
        end
    endtask

    task automatic step(input logic [2:0] k);
        begin
            dat_v[3:1] = k;
            @(negedge sys_clk);
        end
    endtask

    // strobes end while data still stands, giving write hold
    task automatic idle();
        begin
            {c0, c1, c2, pd3} = 4'hf;
            @(negedge sys_clk);
        end
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps

module tb_top;
    typedef struct packed {
        logic [2:0] mode;
        logic [3:0] pins;
        logic       a0;
        logic [1:0] rd;
        logic [1:0] wr;
    } mbli_row_t;

    logic                 sys_clk = 1'b0;
    logic                 arst_n  = 1'b0;
    logic                 sel     = 1'b1;
    logic [7:0]           abc     = 8'h9b;
    mbli_pkg::mbli_cfg_t  cfg     = 5'h00;
    mbli_pkg::mbli_word_t rdw     = 16'hc33c;
    mbli_pkg::mbli_word_t wr_data;
    logic [15:0]          sh_i, sh_o;
    logic [7:0]           f_i, f_o, g_i, g_o;
    logic                 sh_oe, f_oe, g_oe, c0, c1, c2, pd3, pd0;
    logic [23:0]          addr;
    logic [1:0]           rd_en, wr_en;
    logic                 pld_c2, c2_free, d3_free, fn_free;
    mbli_row_t            rows [25];
    int                   error_cnt = 0;
    int                   checked   = 0;

    always #5 sys_clk = ~sys_clk;

    mbli_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_i(cfg),
        .shared_addr_data_port_i(sh_i), .shared_addr_data_port_o(sh_o),
        .shared_addr_data_port_oe(sh_oe), .control_pin_zero(c0), .control_pin_one(c1),
        .control_pin_two(c2), .port_d_bit_three(pd3), .port_d_bit_zero(pd0),
        .port_f_i(f_i), .port_f_o(f_o), .port_f_oe(f_oe), .port_g_i(g_i),
        .port_g_o(g_o), .port_g_oe(g_oe), .port_abc_addr_i(abc), .select_i(sel),
        .rd_data_i(rdw), .addr_o(addr), .rd_en_o(rd_en), .wr_en_o(wr_en),
        .wr_data_o(wr_data), .pld_control_pin_two_o(pld_c2), .control_pin_two_free_o(c2_free),
        .port_d3_free_o(d3_free), .port_f_nib_free_o(fn_free));

    mbli_host host (.sys_clk(sys_clk), .shared_o(sh_o), .shared_oe(sh_oe), .f_o(f_o),
        .f_oe(f_oe), .g_o(g_o), .g_oe(g_oe), .shared_i(sh_i), .f_i(f_i), .g_i(g_i),
        .c0(c0), .c1(c1), .c2(c2), .pd3(pd3), .pd0(pd0));

    // ****
    // helpers
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        begin
            checked++;
            if (got !== exp) begin
                error_cnt++;
                $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
            end
        end
    endtask

    task automatic give_verdict();
        begin
            $display("errors %0d checks %0d", error_cnt, checked);
            if (error_cnt == 0 && checked > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask

    // mode is fixed only while reset holds
    task automatic do_reset(input logic [2:0] m, input logic [1:0] sb);
        begin
            arst_n = 1'b0;
            cfg = {m, sb};
            repeat (3) @(negedge sys_clk);
            chk({addr, rd_en, wr_en, sh_oe, f_oe, g_oe, c2_free}, 32'h0, "reset");
            arst_n = 1'b1;
        end
    endtask

    task automatic run_row(input mbli_row_t r);
        logic        mux, uodd, up, lo, c2f;
        logic [1:0]  en;
        logic [15:0] adr, dat, rdb, got, wm, rm;
        begin
            mux = r.mode < 3'h3;
            uodd = r.mode < 3'h4;
            en = (r.rd != 2'h0) ? r.rd : r.wr;
            up = uodd ? en[1] : en[0];
            lo = uodd ? en[0] : en[1];
            adr = {15'h35a6, r.a0};
            dat = 16'hd24e;
            rdb = uodd ? 16'hc33c : 16'h3cc3;
            wm = {{8{r.wr[1]}}, {8{r.wr[0]}}};
            rm = {{8{up}}, {8{lo}}};
            c2f = (r.mode == 3'h1) || (r.mode == 3'h3);
            do_reset(r.mode, 2'h2);
            host.strobe(adr);
            host.access(r.pins, dat, r.rd == 2'h0, mux);
            chk({rd_en, wr_en}, {r.rd, r.wr}, "lanes");
            chk(addr, (r.mode == 3'h2) ? {abc[3:0], adr, 4'h0} : {abc, adr}, "addr");
            chk(wr_data & wm, (uodd ? dat : {dat[7:0], dat[15:8]}) & wm, "wdata");
            got = mux ? sh_o : {g_o, f_o};
            if (r.rd != 2'h0) chk(got & rm, rdb & rm, "rdata");
            chk({sh_oe, f_oe | g_oe}, (r.rd == 2'h0) ? 2'h0 : (mux ? 2'h2 : 2'h1), "oe");
            chk({c2_free, pld_c2, d3_free}, {c2f, c2f & r.pins[1], !c2f && r.mode != 3'h2}, "free");
            chk(fn_free, mux && r.mode != 3'h2, "fnib");
            host.idle();
            chk({rd_en, wr_en, sh_oe, f_oe, g_oe}, 24'h0, "idle");
        end
    endtask

    // ****
    // tests
    // ****
    initial begin
        // mode 0 bhe, 1 mux wrlh, 2 burst, 3 nm wrlh, 4 size, 5 data strobes
        rows = '{'{3'h0, 4'h5, 1'h0, 2'h0, 2'h3}, '{3'h0, 4'h5, 1'h1, 2'h0, 2'h2},
                 '{3'h0, 4'h7, 1'h0, 2'h0, 2'h1}, '{3'h0, 4'h9, 1'h0, 2'h3, 2'h0},
                 '{3'h0, 4'hb, 1'h0, 2'h1, 2'h0}, '{3'h1, 4'h6, 1'h0, 2'h0, 2'h3},
                 '{3'h1, 4'he, 1'h0, 2'h0, 2'h2}, '{3'h1, 4'h7, 1'h0, 2'h0, 2'h1},
                 '{3'h1, 4'hb, 1'h1, 2'h3, 2'h0}, '{3'h2, 4'h6, 1'h0, 2'h0, 2'h3},
                 '{3'h2, 4'hd, 1'h0, 2'h3, 2'h0}, '{3'h2, 4'hb, 1'h0, 2'h3, 2'h0},
                 '{3'h3, 4'h6, 1'h0, 2'h0, 2'h3}, '{3'h3, 4'he, 1'h0, 2'h0, 2'h2},
                 '{3'h3, 4'h7, 1'h0, 2'h0, 2'h1}, '{3'h3, 4'hb, 1'h1, 2'h3, 2'h0},
                 '{3'h4, 4'h1, 1'h0, 2'h0, 2'h3}, '{3'h4, 4'h3, 1'h0, 2'h0, 2'h1},
                 '{3'h4, 4'h3, 1'h1, 2'h0, 2'h2}, '{3'h4, 4'h9, 1'h0, 2'h3, 2'h0},
                 '{3'h4, 4'hb, 1'h1, 2'h2, 2'h0}, '{3'h5, 4'h1, 1'h0, 2'h0, 2'h3},
                 '{3'h5, 4'h3, 1'h0, 2'h0, 2'h1}, '{3'h5, 4'h5, 1'h0, 2'h0, 2'h2},
                 '{3'h5, 4'h9, 1'h0, 2'h3, 2'h0}};
        foreach (rows[i]) run_row(rows[i]);
        // deselected accesses must neither strobe nor drive
        do_reset(3'h3, 2'h2);
        sel = 1'b0;
        host.strobe(16'h1234);
        host.access(4'h6, 16'h5678, 1'b1, 1'b0);
        chk({wr_en, rd_en, sh_oe, f_oe, g_oe}, 24'h0, "desel write");
        host.idle();
        host.access(4'hb, 16'h0000, 1'b0, 1'b0);
        chk({wr_en, rd_en, sh_oe, f_oe, g_oe}, 24'h0, "desel read");
        host.idle();
        sel = 1'b1;
        // burst: upper address held while the low bits step
        do_reset(3'h2, 2'h2);
        host.strobe(16'ha5c3);
        host.access(4'hd, 16'h0000, 1'b0, 1'b1);
        for (int k = 7; k >= 0; k--) begin
            host.step(3'(k));
            chk(addr, {abc[3:0], 16'ha5c3, 3'(k), 1'b0}, "burst addr");
            chk({rd_en, sh_oe}, 3'h7, "burst read");
        end
        host.idle();
        // strobed non-multiplexed address holds while the port moves on
        do_reset(3'h3, 2'h3);
        host.strobe(16'h1357);
        host.access(4'h4, 16'h0f0f, 1'b1, 1'b1);
        chk(addr, {abc, 16'h1357}, "latched addr");
        chk({wr_en, c2_free, pld_c2}, 4'he, "pin two to logic");
        host.idle();
        give_verdict();
    end

    // the tests need well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        give_verdict();
    end
endmodule
